// *** ipwdt_host.sv ***
// ipwdt_host: host processor model driving the index and data ports
`default_nettype none
module ipwdt_host (
   // clock
   input  wire logic       clk,
   // port access
   output var  logic [7:0] io_addr,
   output var  logic       io_wr,
   output var  logic       io_rd,
   output var  logic [7:0] io_wdata,
   input  wire logic [7:0] io_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   // lines idle at start
   initial {io_addr, io_wr, io_rd, io_wdata} = '0;
   // one access held for one strobe cycle; released address and data show their inverse, strobes drop low
   task automatic acc(input logic rd, input logic [7:0] a, input logic [7:0] v, output logic [7:0] q);
      @(posedge clk) #1;
      {io_addr, io_wdata, io_wr, io_rd} = {a, v, !rd, rd};
      @(posedge clk) #1;
      {io_addr, io_wdata, io_wr, io_rd} = {~a, ~v, 2'b00};
      q = io_rdata;
   endtask : acc
endmodule : ipwdt_host
`default_nettype wire

// *** ipwdt_pkg.sv ***
// ipwdt_pkg: constants for the indexed port watchdog timer
`default_nettype none
package ipwdt_pkg;
   // ---------------------------------------------------------------
   // port addresses and key values
   // ---------------------------------------------------------------
   localparam logic [7:0] IPWDT_ADDR_PORT    = 8'h2e;
   localparam logic [7:0] IPWDT_DATA_PORT    = 8'h2f;
   localparam logic [7:0] IPWDT_UNLOCK_KEY   = 8'h87;
   localparam logic [7:0] IPWDT_LOCK_KEY     = 8'haa;
   localparam logic [7:0] IPWDT_WDT_UNIT     = 8'h08;
   // ---------------------------------------------------------------
   // register indices
   // ---------------------------------------------------------------
   localparam logic [7:0] IPWDT_IDX_UNIT_SEL = 8'h07;
   localparam logic [7:0] IPWDT_IDX_ACTIVATE = 8'h30;
   localparam logic [7:0] IPWDT_IDX_MODE     = 8'hf5;
   localparam logic [7:0] IPWDT_IDX_COUNT    = 8'hf6;
   localparam logic [7:0] IPWDT_IDX_CTRL     = 8'hf7;
   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int         IPWDT_MODE_MIN_BIT = 3;
   localparam int         IPWDT_CTRL_MS_BIT  = 7;
   localparam int         IPWDT_CTRL_KB_BIT  = 6;
   localparam int         IPWDT_CTRL_FT_BIT  = 5;
   localparam int         IPWDT_CTRL_ST_BIT  = 4;
   localparam logic [7:0] IPWDT_ACT_ON       = 8'h01;
   localparam logic [7:0] IPWDT_RST_BYTE     = 8'h00;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int         IPWDT_CLK_HZ       = 100_000_000;
   localparam int         IPWDT_SEC_S        = 1;
   localparam int         IPWDT_SEC_CYC      = IPWDT_SEC_S * IPWDT_CLK_HZ;
   localparam int         IPWDT_MIN_SEC      = 60;
   localparam int         IPWDT_ALERT_S_CYC  = 1;
endpackage : ipwdt_pkg
`default_nettype wire

// *** ipwdt_properties.sv ***
// ipwdt_properties: port assertions for the indexed port watchdog
`default_nettype none
module ipwdt_properties
   import ipwdt_pkg::*;
(
   // clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // host port
   input wire logic [7:0] io_addr,
   input wire logic       io_wr,
   input wire logic       io_rd,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   // strap and timeout actions
   input wire logic       timeout_action_jumper,
   input wire logic       sys_reset_req,
   input wire logic       watchdog_alert_pin
);
   logic       key_q;
   logic       open_q;
   logic [7:0] idx_q;
   logic       idx_wr;
   logic       data_rd;
   logic       idx_mapped;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // shadow of the key pair, the open state and the index in use
   assign idx_wr = io_wr && io_addr == IPWDT_ADDR_PORT;
   // data port read and whether the index in use names a register
   assign data_rd    = io_rd && io_addr == IPWDT_DATA_PORT;
   assign idx_mapped = idx_q inside {IPWDT_IDX_UNIT_SEL, IPWDT_IDX_ACTIVATE, IPWDT_IDX_MODE, IPWDT_IDX_COUNT,
                                     IPWDT_IDX_CTRL};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         key_q  <= 1'b0;
         open_q <= 1'b0;
         idx_q  <= 8'h00;
      end else if (io_wr) begin
         key_q <= idx_wr && io_wdata == IPWDT_UNLOCK_KEY;
         if (key_q && idx_wr && io_wdata == IPWDT_UNLOCK_KEY)
            open_q <= 1'b1;
         else if (open_q && idx_wr && io_wdata == IPWDT_LOCK_KEY)
            open_q <= 1'b0;
         else if (open_q && idx_wr)
            idx_q <= io_wdata;
      end
   end
   // two quiet cycles straight after release
   sequence s_quiet2;
      (!sys_reset_req && io_rdata == 8'h00) [*2];
   endsequence
   a_reset_quiet: assert property (disable iff (1'b0) !rst_n |-> !sys_reset_req && !watchdog_alert_pin)
      else $error("outputs active in reset");
   a_release_quiet: assert property ($rose(rst_n) |-> s_quiet2)
      else $error("output active after release");
   a_read_needs_strobe: assert property (!$past(io_rd) |-> io_rdata == 8'h00)
      else $error("read data without read");
   a_locked_read_zero: assert property (io_rd && !open_q |=> io_rdata == 8'h00)
      else $error("locked read not zero");
   a_unmapped_read_zero: assert property (data_rd && !idx_mapped |=> io_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_reset_needs_jumper: assert property (sys_reset_req |-> $past(timeout_action_jumper))
      else $error("reset action with jumper low");
   a_toggle_needs_jumper: assert property ($changed(watchdog_alert_pin) |-> !$past(timeout_action_jumper))
      else $error("pin toggle with jumper high");
   a_actions_exclusive: assert property (sys_reset_req |-> $stable(watchdog_alert_pin))
      else $error("both timeout actions at once");
endmodule : ipwdt_properties
bind ipwdt_top ipwdt_properties i_ipwdt_properties (.clk, .rst_n, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
   .timeout_action_jumper, .sys_reset_req, .watchdog_alert_pin);
`default_nettype wire

// *** ipwdt_top.sv ***
// ipwdt_top: indexed port watchdog timer with key-guarded configuration
//
// Behaviour
// - index to address port, data via data port
// - unlock key written twice opens configuration
// - unit number selects watchdog register set
// - inactive after reset until activation written one
// - mode bit chooses seconds or minutes
// - zero count stops, nonzero runs timer
// - count write restarts countdown from new value
// - countdown end produces timeout output
// - jumper picks reset or pin toggle
// - keyboard restart when enable bit set
// - force bit times out at once, self-clears
// - status bit reads one after timeout
// - lock key closes configuration access
// - mouse restart when enable bit set
`default_nettype none
module ipwdt_top
   import ipwdt_pkg::*;
#(
   parameter int SEC_CYC = ipwdt_pkg::IPWDT_SEC_CYC
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // host i/o port access
   input  wire logic [7:0] io_addr,
   input  wire logic       io_wr,
   input  wire logic       io_rd,
   input  wire logic [7:0] io_wdata,
   output var  logic [7:0] io_rdata,
   // restart sources and strap
   input  wire logic       kbd_activity,
   input  wire logic       mouse_activity,
   input  wire logic       timeout_action_jumper,
   // timeout actions
   output var  logic       sys_reset_req,
   output var  logic       watchdog_alert_pin
);
   import ipwdt_pkg::*;

   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   logic rst_s1_q;
   logic rst_s2_q;
   logic rst_l;
   // two stage release of the asynchronous reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   assign rst_l = rst_s2_q;

   // ---------------------------------------------------------------
   // port decode and key sequence
   // ---------------------------------------------------------------
   logic       unlocked_q;
   logic       key_seen_q;
   logic [7:0] index_q;
   logic [7:0] unit_q;
   logic       wr_addr;
   logic       wr_data;
   logic       rd_data;
   logic       is_unlock;
   logic       is_lock;
   logic       wdt_sel;
   logic       cfg_wr;
   // address and data port strobes
   assign wr_addr   = io_wr && (io_addr == IPWDT_ADDR_PORT);
   assign wr_data   = io_wr && (io_addr == IPWDT_DATA_PORT);
   assign rd_data   = io_rd && (io_addr == IPWDT_DATA_PORT);
   assign is_unlock = wr_addr && (io_wdata == IPWDT_UNLOCK_KEY);
   assign is_lock   = wr_addr && (io_wdata == IPWDT_LOCK_KEY) && unlocked_q;
   assign wdt_sel   = (unit_q == IPWDT_WDT_UNIT);
   assign cfg_wr    = wr_data && unlocked_q;

   // lock state: two back-to-back unlock keys open, lock key closes
   always_ff @(posedge clk or negedge rst_l) begin
      if (!rst_l) begin
         unlocked_q <= 1'b0;
         key_seen_q <= 1'b0;
      end else if (wr_addr) begin
         key_seen_q <= is_unlock && !unlocked_q;
         if (is_unlock && key_seen_q)
            unlocked_q <= 1'b1;
         else if (is_lock)
            unlocked_q <= 1'b0;
      end else if (wr_data) begin
         key_seen_q <= 1'b0;
      end
   end

   // index latched only while open
   always_ff @(posedge clk or negedge rst_l) begin
      if (!rst_l)
         index_q <= IPWDT_RST_BYTE;
      else if (wr_addr && unlocked_q && !is_lock)
         index_q <= io_wdata;
   end

   // logical unit selection
   always_ff @(posedge clk or negedge rst_l) begin
      if (!rst_l)
         unit_q <= IPWDT_RST_BYTE;
      else if (cfg_wr && index_q == IPWDT_IDX_UNIT_SEL)
         unit_q <= io_wdata;
   end

   // ---------------------------------------------------------------
   // watchdog registers
   // ---------------------------------------------------------------
   logic       active_q;
   logic       minutes_q;
   logic [7:0] count_q;
   logic       kb_en_q;
   logic       ms_en_q;
   logic       status_q;
   logic       wr_act;
   logic       wr_mode;
   logic       wr_cnt;
   logic       wr_ctrl;
   logic       force_to;
   logic       expire;
   logic       restart;
   logic       timeout;
   assign wr_act  = cfg_wr && wdt_sel && index_q == IPWDT_IDX_ACTIVATE;
   assign wr_mode = cfg_wr && wdt_sel && index_q == IPWDT_IDX_MODE;
   assign wr_cnt  = cfg_wr && wdt_sel && index_q == IPWDT_IDX_COUNT;
   assign wr_ctrl = cfg_wr && wdt_sel && index_q == IPWDT_IDX_CTRL;
   assign force_to = wr_ctrl && io_wdata[IPWDT_CTRL_FT_BIT] && active_q;
   assign restart = active_q && ((kb_en_q && kbd_activity)
                                 || (ms_en_q && mouse_activity));
   assign timeout = expire || force_to;

   // activation, mode and enable bits
   always_ff @(posedge clk or negedge rst_l) begin
      if (!rst_l) begin
         active_q  <= 1'b0;
         minutes_q <= 1'b0;
         kb_en_q   <= 1'b0;
         ms_en_q   <= 1'b0;
      end else begin
         if (wr_act)
            active_q <= (io_wdata == IPWDT_ACT_ON);
         if (wr_mode)
            minutes_q <= io_wdata[IPWDT_MODE_MIN_BIT];
         if (wr_ctrl) begin
            kb_en_q <= io_wdata[IPWDT_CTRL_KB_BIT];
            ms_en_q <= io_wdata[IPWDT_CTRL_MS_BIT];
         end
      end
   end

   // status: a new timeout wins over a software clear of the bit
   always_ff @(posedge clk or negedge rst_l) begin
      if (!rst_l)
         status_q <= 1'b0;
      else if (timeout)
         status_q <= 1'b1;
      else if (wr_ctrl && !io_wdata[IPWDT_CTRL_ST_BIT])
         status_q <= 1'b0;
   end

   // ---------------------------------------------------------------
   // countdown
   // ---------------------------------------------------------------
   logic [7:0]  reload_q;
   logic [31:0] tick_q;
   logic [5:0]  sec_q;
   logic        sec_tick;
   logic        unit_tick;
   // prescaler ticks; a reload in the expiry cycle restarts instead of timing out
   assign sec_tick  = (tick_q == 32'(SEC_CYC - 1));
   assign unit_tick = sec_tick && (!minutes_q || sec_q == 6'(IPWDT_MIN_SEC - 1));
   assign expire    = active_q && count_q == 8'h01 && unit_tick && !wr_cnt && !restart;

   // count register, prescaler and reload value
   always_ff @(posedge clk or negedge rst_l) begin
      if (!rst_l) begin
         count_q  <= IPWDT_RST_BYTE;
         reload_q <= IPWDT_RST_BYTE;
         tick_q   <= 32'h0;
         sec_q    <= 6'h0;
      end else if (wr_cnt) begin
         count_q  <= io_wdata;
         reload_q <= io_wdata;
         tick_q   <= 32'h0;
         sec_q    <= 6'h0;
      end else if (restart) begin
         count_q  <= reload_q;
         tick_q   <= 32'h0;
         sec_q    <= 6'h0;
      end else if (active_q && count_q != 8'h00) begin
         tick_q <= sec_tick ? 32'h0 : tick_q + 32'h1;
         if (sec_tick)
            sec_q <= (unit_tick ? 6'h0 : sec_q + 6'h1);
         if (unit_tick)
            count_q <= count_q - 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   logic [7:0] rdata_d;
   assign rdata_d = !(rd_data && unlocked_q && wdt_sel) ? IPWDT_RST_BYTE :
                    (index_q == IPWDT_IDX_ACTIVATE) ? {7'h0, active_q} :
                    (index_q == IPWDT_IDX_MODE) ? 8'(minutes_q) << IPWDT_MODE_MIN_BIT :
                    (index_q == IPWDT_IDX_COUNT) ? count_q :
                    (index_q == IPWDT_IDX_CTRL) ? {ms_en_q, kb_en_q, 1'b0, status_q, 4'h0} :
                    IPWDT_RST_BYTE;

   // registered read data and timeout actions
   always_ff @(posedge clk or negedge rst_l) begin
      if (!rst_l) begin
         io_rdata           <= IPWDT_RST_BYTE;
         sys_reset_req      <= 1'b0;
         watchdog_alert_pin <= 1'b0;
      end else begin
         io_rdata      <= rdata_d;
         sys_reset_req <= timeout && timeout_action_jumper;
         if (timeout && !timeout_action_jumper)
            watchdog_alert_pin <= !watchdog_alert_pin;
      end
   end
endmodule : ipwdt_top
`default_nettype wire

// *** test_indexed_port_watchdog_timer.sv ***
// test_indexed_port_watchdog_timer: self-checking bench for the watchdog
`default_nettype none
module test_indexed_port_watchdog_timer;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int S = 10;
   typedef struct packed {logic [7:0] idx; logic wr; logic [7:0] wd; logic [7:0] exp;} ipwdt_row_t;
   ipwdt_row_t rows [3] = '{'{8'hf7, 1'b1, 8'hc0, 8'hc0}, '{8'h20, 1'b0, 8'h00, 8'h00}, '{8'hf6, 1'b1, 8'h00, 8'h00}};
   logic       clk, rst_n, io_wr, io_rd, kbd, mouse, jmp, srst, pin;
   logic [7:0] io_addr, io_wdata, io_rdata, q;
   int         bad_count, comparisons, n;
   ipwdt_top #(.SEC_CYC(S)) i_ipwdt_top (.clk, .rst_n, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
      .kbd_activity(kbd), .mouse_activity(mouse), .timeout_action_jumper(jmp), .sys_reset_req(srst),
      .watchdog_alert_pin(pin));
   ipwdt_host i_ipwdt_host (.clk, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata);
   // 100 mhz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic ok, input string m);
      comparisons++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   task automatic key(input logic [7:0] v);
      i_ipwdt_host.acc(1'b0, 8'h2e, v, q);
   endtask : key
   task automatic wreg(input logic [7:0] i, input logic [7:0] v);
      i_ipwdt_host.acc(1'b0, 8'h2e, i, q);
      i_ipwdt_host.acc(1'b0, 8'h2f, v, q);
   endtask : wreg
   task automatic rreg(input logic [7:0] i);
      i_ipwdt_host.acc(1'b0, 8'h2e, i, q);
      i_ipwdt_host.acc(1'b1, 8'h2f, 8'h00, q);
   endtask : rreg
   // cycles until a timeout action shows, lim+1 when none does
   task automatic wait_tmo(input int lim);
      logic p;
      p = pin;
      n = 0;
      while (n <= lim && srst !== 1'b1 && pin === p) begin
         @(posedge clk) #1;
         n++;
      end
   endtask : wait_tmo
   function automatic logic in_win(int u);
      return n >= (u - 1) * S + 1 && n <= u * S + 3;
   endfunction : in_win
   task automatic do_reset;
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk(srst === 1'b0 && pin === 1'b0 && io_rdata === 8'h00, "reset state");
   endtask : do_reset
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict
   // main sequence
   initial begin
      {rst_n, kbd, mouse, jmp, bad_count, comparisons} = {4'b0001, 64'd0};
      do_reset;
      wreg(8'h07, 8'h08);
      wreg(8'h30, 8'h01);
      wreg(8'hf6, 8'h01);
      wait_tmo(3 * S);
      rreg(8'hf6);
      chk(n > 3 * S && q === 8'h00, "locked access acted");
      key(8'h87);
      key(8'h87);
      wreg(8'h07, 8'h08);
      foreach (rows[i]) begin
         if (rows[i].wr)
            wreg(rows[i].idx, rows[i].wd);
         rreg(rows[i].idx);
         chk(q === rows[i].exp, "readback");
      end
      wreg(8'h30, 8'h01);
      wreg(8'hf6, 8'h02);
      wait_tmo(5 * S);
      chk(in_win(2) && srst === 1'b1, "seconds expiry");
      rreg(8'hf7);
      chk(q[4] === 1'b1, "status");
      wreg(8'hf6, 8'h03);
      wait_tmo(2 * S);
      wreg(8'hf6, 8'h03);
      wait_tmo(5 * S);
      chk(in_win(3), "reload");
      for (int k = 0; k < 2; k++) begin
         wreg(8'hf7, k == 0 ? 8'h40 : 8'h80);
         wreg(8'hf6, 8'h03);
         wait_tmo(2 * S);
         {kbd, mouse} = k == 0 ? 2'b10 : 2'b01;
         @(posedge clk) #1;
         {kbd, mouse} = 2'b00;
         wait_tmo(5 * S);
         chk(in_win(3), "activity restart");
      end
      wreg(8'hf5, 8'h08);
      wreg(8'hf6, 8'h01);
      wait_tmo(70 * S);
      chk(n > 59 * S && n <= 60 * S + 3, "minute unit");
      wreg(8'hf5, 8'h00);
      jmp = 1'b0;
      wreg(8'hf7, 8'h20);
      wait_tmo(3);
      chk(pin === 1'b1, "forced toggle");
      rreg(8'hf7);
      chk(q[5] === 1'b0, "force bit clear");
      wreg(8'hf6, 8'h02);
      key(8'haa);
      wreg(8'hf6, 8'h00);
      wait_tmo(5 * S);
      chk(in_win(2) && pin === 1'b0, "locked count");
      key(8'h87);
      key(8'h87);
      wreg(8'hf6, 8'h00);
      wait_tmo(3 * S);
      chk(n > 3 * S, "zero count ran");
      wreg(8'h30, 8'h00);
      wreg(8'hf6, 8'h01);
      wait_tmo(3 * S);
      chk(n > 3 * S, "inactive ran");
      wreg(8'h30, 8'h01);
      wreg(8'hf6, 8'h02);
      do_reset;
      wait_tmo(3 * S);
      chk(n > 3 * S, "reset kept timer");
      print_verdict;
   end
endmodule : test_indexed_port_watchdog_timer
`default_nettype wire
